// *** src/wsr_map.vh ***
// Purpose: constants for the wake and signature read block
// Assumes: 50 MHz mclk
// Notes: times in ns, counts derived in the module
`ifndef WSR_MAP_VH
`define WSR_MAP_VH
`define WSR_CLK_NS 20
`define WSR_SIG_BITS 8
`define WSR_DUMMY_BYTES 3
`define WSR_BYTE_BITS 8
`define WSR_CMD_WAKE 8'hab
`define WSR_CMD_SLEEP 8'hb9
`define WSR_CMD_UNLOCK 8'h06
`define WSR_CMD_PAGE 8'h02
`define WSR_CMD_SMALL 8'h20
`define WSR_CMD_BLOCK 8'hd8
`define WSR_CMD_STATUS 8'h01
`define WSR_SIGNATURE 8'h5a
`define WSR_ARRAY_ERASED 8'hff
`define WSR_STATUS_RESET 8'h00
`define WSR_SHORT_WAKE_NS 3000
`define WSR_FULL_WAKE_NS 1800
`define WSR_SLEEP_ENTRY_NS 3000
`define WSR_INHIBIT_NS 10000000
`define WSR_SELECT_WAIT_NS 5000000
`define WSR_MEM_AW 4
`endif

// *** src/wsr_sig_rom.v ***
// Purpose: small register-read store for the signature and delivery state
// Assumes: read data registered
// Notes: index 0 signature, 1 erased array byte, 2 status reset value
`timescale 1ns/1ns
`include "wsr_map.vh"
module wsr_sig_rom #(
    parameter [7:0] SIG = `WSR_SIGNATURE
) (
    input wire mclk,
    input wire [`WSR_MEM_AW-1:0] addr,
    output reg [7:0] rdata
);
    always @(posedge mclk) begin
        case (addr)
            4'h0: rdata <= SIG;
            4'h1: rdata <= `WSR_ARRAY_ERASED;
            4'h2: rdata <= `WSR_STATUS_RESET;
            default: rdata <= 8'h00;
        endcase
    end
endmodule

// *** src/wsr_top.v ***
// Purpose: wake from deep sleep and signature read over serial pins
// Assumes: link clock sampled by mclk, far slower than mclk
// Notes: supply valid level comes in as a pin, synchronised
`timescale 1ns/1ns
`include "wsr_map.vh"
module wsr_top #(
    // Wake and sleep opcodes, signature and delays stay tunable
    parameter [7:0] WAKE_OP = `WSR_CMD_WAKE,
    parameter [7:0] SLEEP_OP = `WSR_CMD_SLEEP,
    parameter [7:0] SIGNATURE = `WSR_SIGNATURE,
    parameter SHORT_WAKE_NS = `WSR_SHORT_WAKE_NS,
    parameter FULL_WAKE_NS = `WSR_FULL_WAKE_NS,
    parameter SLEEP_ENTRY_NS = `WSR_SLEEP_ENTRY_NS,
    parameter INHIBIT_CYC = `WSR_INHIBIT_NS / `WSR_CLK_NS,
    parameter SEL_WAIT_CYC = `WSR_SELECT_WAIT_NS / `WSR_CLK_NS
) (
    input wire mclk,
    input wire rst,
    input wire select_n,
    input wire serial_clk,
    input wire serial_input_pin,
    input wire supply_ok,
    input wire cycle_busy,
    output reg serial_out_r,
    output reg serial_out_en_r,
    output reg deep_sleep_r,
    output reg standby_r,
    output reg write_latch_flag_r,
    output reg cycle_running_flag_r,
    output reg write_allowed_r,
    output reg read_allowed_r,
    output reg [7:0] status_r,
    output reg [7:0] cmd_byte_r,
    output reg cmd_valid_r
);
    // ----------------------------------------
    // Timing counts (rounded up to whole mclk cycles, no minimum)
    // ----------------------------------------
    localparam SHORT_CYC = (SHORT_WAKE_NS + `WSR_CLK_NS - 1) / `WSR_CLK_NS;
    localparam FULL_CYC = (FULL_WAKE_NS + `WSR_CLK_NS - 1) / `WSR_CLK_NS;
    localparam SLEEP_CYC = (SLEEP_ENTRY_NS + `WSR_CLK_NS - 1) / `WSR_CLK_NS;
    localparam [2:0] ST_CMD = 3'h0;
    localparam [2:0] ST_DUMMY = 3'h1;
    localparam [2:0] ST_SIG = 3'h2;
    localparam [2:0] ST_IGNORE = 3'h3;
    localparam [2:0] ST_IDLE = 3'h4;

    function is_write_cmd;
        input [7:0] op;
        begin
            is_write_cmd = (op == `WSR_CMD_UNLOCK) || (op == `WSR_CMD_PAGE) ||
                (op == `WSR_CMD_SMALL) || (op == `WSR_CMD_BLOCK) ||
                (op == `WSR_CMD_STATUS);
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [1:0] sel_s_r, clk_s_r, din_s_r, sup_s_r;
    reg clk_d_r, sel_d_r;
    always @(posedge mclk) begin
        sel_s_r <= {sel_s_r[0], select_n};
        clk_s_r <= {clk_s_r[0], serial_clk};
        din_s_r <= {din_s_r[0], serial_input_pin};
        sup_s_r <= {sup_s_r[0], supply_ok};
        clk_d_r <= clk_s_r[1];
        sel_d_r <= sel_s_r[1];
    end
    wire sel = ~sel_s_r[1];
    wire rise = clk_s_r[1] & ~clk_d_r;
    wire fall = ~clk_s_r[1] & clk_d_r;
    wire sel_up = sel_s_r[1] & ~sel_d_r;
    // Logic is held in reset while supply is below threshold
    wire lrst = rst | ~sup_s_r[1];

    // ----------------------------------------
    // Signature store
    // ----------------------------------------
    wire [7:0] sig_byte;
    wsr_sig_rom #(.SIG(SIGNATURE)) u_rom (
        .mclk(mclk),
        .addr(4'h0),
        .rdata(sig_byte)
    );

    // ----------------------------------------
    // Power-up delays
    // ----------------------------------------
    reg [31:0] pu_cnt_r;
    always @(posedge mclk) begin
        if (lrst) begin
            pu_cnt_r <= 32'h0;
            write_allowed_r <= 1'b0;
            read_allowed_r <= 1'b0;
        end else begin
            if (pu_cnt_r != 32'hffffffff)
                pu_cnt_r <= pu_cnt_r + 32'h1;
            write_allowed_r <= (pu_cnt_r >= INHIBIT_CYC);
            read_allowed_r <= (pu_cnt_r >= SEL_WAIT_CYC);
        end
    end

    // ----------------------------------------
    // Serial decoder
    // ----------------------------------------
    reg [2:0] st_r;
    reg [2:0] bit_r;
    reg [1:0] dby_r;
    reg [7:0] sh_r;
    reg [7:0] out_sh_r;
    reg sig_done_r;
    reg wake_seen_r;
    reg sleep_seen_r;
    reg [31:0] dly_r;
    reg waking_r;
    reg sleeping_r;
    wire [7:0] nxt_byte = {sh_r[6:0], din_s_r[1]};
    wire last_bit = (bit_r == 3'h7);

    always @(posedge mclk) begin
        if (lrst) begin
            st_r <= ST_IDLE;
            bit_r <= 3'h0;
            dby_r <= 2'h0;
            sh_r <= 8'h0;
            out_sh_r <= 8'h0;
            sig_done_r <= 1'b0;
            wake_seen_r <= 1'b0;
            sleep_seen_r <= 1'b0;
            dly_r <= 32'h0;
            waking_r <= 1'b0;
            sleeping_r <= 1'b0;
            deep_sleep_r <= 1'b0;
            standby_r <= 1'b1;
            write_latch_flag_r <= 1'b0;
            cycle_running_flag_r <= 1'b0;
            status_r <= `WSR_STATUS_RESET;
            serial_out_r <= 1'b0;
            serial_out_en_r <= 1'b0;
            cmd_byte_r <= 8'h0;
            cmd_valid_r <= 1'b0;
        end else begin
            cmd_valid_r <= 1'b0;
            cycle_running_flag_r <= cycle_busy;
            status_r <= {7'h0, cycle_busy};
            if (dly_r != 32'h0) begin
                dly_r <= dly_r - 32'h1;
            end else if (waking_r) begin
                waking_r <= 1'b0;
                deep_sleep_r <= 1'b0;
                standby_r <= 1'b1;
            end else if (sleeping_r) begin
                sleeping_r <= 1'b0;
                deep_sleep_r <= 1'b1;
                standby_r <= 1'b0;
            end
            if (sel_up) begin
                serial_out_en_r <= 1'b0;
                st_r <= ST_IDLE;
                // Partial command byte aborts with no effect
                if (wake_seen_r && !deep_sleep_r) begin
                    standby_r <= 1'b1;
                end else if (wake_seen_r) begin
                    waking_r <= 1'b1;
                    dly_r <= sig_done_r ? FULL_CYC - 1 : SHORT_CYC - 1;
                end else if (sleep_seen_r && !cycle_busy) begin
                    sleeping_r <= 1'b1;
                    dly_r <= SLEEP_CYC - 1;
                end
                wake_seen_r <= 1'b0;
                sleep_seen_r <= 1'b0;
            end else if (sel && st_r == ST_IDLE) begin
                st_r <= read_allowed_r ? ST_CMD : ST_IGNORE;
                bit_r <= 3'h0;
                sig_done_r <= 1'b0;
                standby_r <= 1'b0;
            end else if (sel) begin
                case (st_r)
                    ST_CMD: if (rise) begin
                        sh_r <= nxt_byte;
                        bit_r <= bit_r + 3'h1;
                        if (last_bit) begin
                            cmd_byte_r <= nxt_byte;
                            dby_r <= 2'h0;
                            st_r <= ST_IGNORE;
                            if (cycle_busy) begin
                                st_r <= ST_IGNORE;
                            end else if (nxt_byte == WAKE_OP) begin
                                wake_seen_r <= 1'b1;
                                st_r <= ST_DUMMY;
                            end else if (deep_sleep_r || sleeping_r) begin
                                st_r <= ST_IGNORE;
                            end else if (nxt_byte == SLEEP_OP) begin
                                sleep_seen_r <= 1'b1;
                            end else if (!is_write_cmd(nxt_byte) ||
                                    write_allowed_r) begin
                                cmd_valid_r <= 1'b1;
                                if (nxt_byte == `WSR_CMD_UNLOCK)
                                    write_latch_flag_r <= 1'b1;
                            end
                        end
                    end
                    ST_DUMMY: if (rise) begin
                        bit_r <= bit_r + 3'h1;
                        if (last_bit) begin
                            dby_r <= dby_r + 2'h1;
                            if (dby_r == `WSR_DUMMY_BYTES - 1) begin
                                st_r <= ST_SIG;
                                out_sh_r <= sig_byte;
                            end
                        end
                    end
                    ST_SIG: if (fall) begin
                        serial_out_en_r <= 1'b1;
                        serial_out_r <= out_sh_r[7];
                        bit_r <= bit_r + 3'h1;
                        // Reload wraps the byte for repeated output
                        out_sh_r <= last_bit ? sig_byte
                            : {out_sh_r[6:0], 1'b0};
                        if (last_bit)
                            sig_done_r <= 1'b1;
                    end
                    default: st_r <= st_r;
                endcase
            end
        end
    end
endmodule

// *** dv/wsr_top_properties.sv ***
// Purpose: port checks for the wake and signature block
// Assumes: one mclk domain, rst active high
// Notes: select and supply pass 2-ff syncs, so bounds allow that lag
`timescale 1ns/1ns
module wsr_top_chk (
    input wire mclk,
    input wire rst,
    input wire select_n,
    input wire supply_ok,
    input wire cycle_busy,
    input wire serial_out_en_r,
    input wire deep_sleep_r,
    input wire standby_r,
    input wire write_latch_flag_r,
    input wire cycle_running_flag_r,
    input wire write_allowed_r,
    input wire read_allowed_r,
    input wire [7:0] status_r,
    input wire cmd_valid_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_status; status_r == {7'h00, cycle_running_flag_r}; endproperty
    a_status: assert property (p_status) else $error("bad status");
    property p_busy; $rose(cycle_busy) |-> ##[1:3] cycle_running_flag_r;
    endproperty
    a_busy: assert property (p_busy) else $error("flag late");
    property p_en_off; select_n [*5] |-> !serial_out_en_r; endproperty
    a_en_off: assert property (p_en_off) else $error("drive on");
    property p_sleep_sel; $rose(deep_sleep_r) |-> select_n; endproperty
    a_sleep_sel: assert property (p_sleep_sel) else $error("early");
    property p_wake; $fell(deep_sleep_r) |-> standby_r; endproperty
    a_wake: assert property (p_wake) else $error("no standby");
    property p_asleep; deep_sleep_r |-> !cmd_valid_r; endproperty
    a_asleep: assert property (p_asleep) else $error("cmd in sleep");
    property p_inhibit; !write_allowed_r |-> !write_latch_flag_r; endproperty
    a_inhibit: assert property (p_inhibit) else $error("latch set");
    property p_por;
        !supply_ok [*5] |-> standby_r && !deep_sleep_r && !read_allowed_r;
    endproperty
    a_por: assert property (p_por) else $error("not held");
endmodule
bind wsr_top wsr_top_chk u_chk (.*);

// *** dv/wsr_host.sv ***
// Purpose: host side of the serial link
// Assumes: link clock 3 mclk high, 5 mclk low
// Notes: link clock idles low between frames
`timescale 1ns/1ns
module wsr_host (
    input wire mclk,
    input wire so,
    output logic sel_n,
    output logic sclk,
    output logic sdi
);
    // Select stays high until the first frame
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Data moves while the clock is low, so it is stable at the rise
    task automatic frame(input logic [7:0] op, input int n,
                         output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge mclk);
        sel_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi <= (i < 8) ? op[7 - i] : i[0];
            repeat (5) @(posedge mclk);
            if (i >= 32) begin
                rx = {rx[14:0], so};
            end
            sclk <= 1'b1;
            repeat (3) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (5) @(posedge mclk);
        sel_n <= 1'b1;
        sdi <= ~sdi;
        // Deselect time covers the sync lag before the next frame
        repeat (8) @(posedge mclk);
    endtask
endmodule

// *** dv/wsr_top_tb.sv ***
// Purpose: self-checking bench for wsr_top
// Assumes: short power-up counts for a brief run
// Notes: long waits are bounded and end the run on timeout
`timescale 1ns/1ns
`include "wsr_map.vh"
module wsr_top_tb;
    logic mclk, rst, supply_ok, cycle_busy;
    wire sel_n, sclk, sdi, so, slp, stb, wl, wa, ra;
    wire [7:0] st, cb;
    wire [2:0] flags = {ra, wa, slp};
    logic [15:0] rx;
    int err_total, comparisons;
    wsr_top #(.INHIBIT_CYC(400), .SEL_WAIT_CYC(20)) u_dut (
        .mclk(mclk), .rst(rst), .select_n(sel_n), .serial_clk(sclk),
        .serial_input_pin(sdi), .supply_ok(supply_ok),
        .cycle_busy(cycle_busy), .serial_out_r(so), .serial_out_en_r(),
        .deep_sleep_r(slp), .standby_r(stb), .write_latch_flag_r(wl),
        .cycle_running_flag_r(), .write_allowed_r(wa),
        .read_allowed_r(ra), .status_r(st), .cmd_byte_r(cb),
        .cmd_valid_r());
    wsr_host u_host (.mclk(mclk), .so(so), .sel_n(sel_n), .sclk(sclk),
        .sdi(sdi));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wait_flag(input int k, input logic v, input int lim);
        int n = 0;
        while (flags[k] !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            finish_test;
        end
    endtask
    initial begin
        rst = 1'b1;
        supply_ok = 1'b1;
        cycle_busy = 1'b0;
        err_total = 0;
        comparisons = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        wait_flag(2, 1'b1, 100);
        check({stb, slp, wl, st}, {3'h4, 8'h00});
        u_host.frame(`WSR_CMD_UNLOCK, 8, rx);
        check(wl, 1'b0);
        u_host.frame(`WSR_CMD_WAKE, 48, rx);
        check(rx, {2{`WSR_SIGNATURE}});
        wait_flag(1, 1'b1, 500);
        u_host.frame(`WSR_CMD_UNLOCK, 8, rx);
        check(wl, 1'b1);
        check(cb, `WSR_CMD_UNLOCK);
        u_host.frame(`WSR_CMD_WAKE, 48, rx);
        check(rx, {2{`WSR_SIGNATURE}});
        check(stb, 1'b1);
        cycle_busy <= 1'b1;
        u_host.frame(`WSR_CMD_SLEEP, 8, rx);
        repeat (200) @(posedge mclk);
        check({slp, st}, 9'h001);
        cycle_busy <= 1'b0;
        u_host.frame(`WSR_CMD_SLEEP, 5, rx);
        repeat (200) @(posedge mclk);
        check(slp, 1'b0);
        u_host.frame(`WSR_CMD_SLEEP, 8, rx);
        wait_flag(0, 1'b1, 300);
        check(stb, 1'b0);
        u_host.frame(`WSR_CMD_UNLOCK, 8, rx);
        cycle_busy <= 1'b1;
        u_host.frame(`WSR_CMD_WAKE, 40, rx);
        check(slp, 1'b1);
        cycle_busy <= 1'b0;
        u_host.frame(`WSR_CMD_WAKE, 40, rx);
        check({slp, rx}, {1'b1, 8'h00, `WSR_SIGNATURE});
        wait_flag(0, 1'b0, 200);
        check(stb, 1'b1);
        u_host.frame(`WSR_CMD_SLEEP, 8, rx);
        wait_flag(0, 1'b1, 300);
        u_host.frame(`WSR_CMD_WAKE, 8, rx);
        check(slp, 1'b1);
        wait_flag(0, 1'b0, 300);
        check(stb, 1'b1);
        supply_ok <= 1'b0;
        repeat (8) @(posedge mclk);
        check({ra, stb}, 2'h1);
        supply_ok <= 1'b1;
        wait_flag(2, 1'b1, 100);
        finish_test;
    end
endmodule
